// File: pidacc_defines.vh
// register offsets, field positions, reset values and timing counts of the pid accelerator
`ifndef PIDACC_DEFINES_VH
`define PIDACC_DEFINES_VH
`define PIDACC_OFF_CONFIG 12'h000
`define PIDACC_OFF_SAMPLE_H 12'h004
`define PIDACC_OFF_SAMPLE_L 12'h008
`define PIDACC_OFF_TARGET_H 12'h00c
`define PIDACC_OFF_TARGET_L 12'h010
`define PIDACC_OFF_GNOW_H 12'h014
`define PIDACC_OFF_GNOW_L 12'h018
`define PIDACC_OFF_GPRI_H 12'h01c
`define PIDACC_OFF_GPRI_L 12'h020
`define PIDACC_OFF_GOLD_H 12'h024
`define PIDACC_OFF_GOLD_L 12'h028
`define PIDACC_OFF_RES_U 12'h02c
`define PIDACC_OFF_RES_HH 12'h030
`define PIDACC_OFF_RES_HL 12'h034
`define PIDACC_OFF_RES_LH 12'h038
`define PIDACC_OFF_RES_LL 12'h03c
`define PIDACC_OFF_IRQ_STAT 12'h040
`define PIDACC_OFF_IRQ_MASK 12'h044
`define PIDACC_BIT_EN 7
`define PIDACC_BIT_BUSY 6
`define PIDACC_MODE_UADD 3'h0
`define PIDACC_MODE_UACC 3'h1
`define PIDACC_MODE_SADD 3'h2
`define PIDACC_MODE_SACC 3'h3
`define PIDACC_MODE_PID 3'h5
`define PIDACC_IRQ_DONE 0
`define PIDACC_IRQ_OVF 1
`define PIDACC_CONFIG_RST 8'h00
`define PIDACC_CALC_CYCLES 4'h4
`endif

// File: pidacc_sva.sv
// assertion checker for the pid accelerator apb port
`include "pidacc_defines.vh"
`default_nettype none
module pidacc_sva (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// helper state and assertions
	// ------------------------------------------------------------
	logic en_seen;
	logic [2:0] busy_cnt;
	wire acc = psel && penable && pready;
	wire rd_cfg = acc && !pwrite && paddr == `PIDACC_OFF_CONFIG;
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// mirror the enable bit and count the busy window after each start
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			en_seen <= 1'h0;
			busy_cnt <= 3'h0;
		end else begin
			if (acc && pwrite && paddr == `PIDACC_OFF_CONFIG)
				en_seen <= pwdata[7];
			if (acc && pwrite && paddr == `PIDACC_OFF_SAMPLE_L && en_seen)
				busy_cnt <= 3'h1;
			else if (busy_cnt != 3'h0)
				busy_cnt <= (busy_cnt == 3'h5) ? 3'h0 : busy_cnt + 3'h1;
		end
	end
	a_answer_bound: assert property (psel && penable |-> ##[0:1] pready)
		else $error("access phase not answered in time");
	a_pready_single: assert property (pready |=> !pready) else $error("pready too long");
	a_err_unmapped: assert property (acc && paddr > `PIDACC_OFF_IRQ_MASK |-> pslverr)
		else $error("unmapped access not refused");
	a_no_err_mapped: assert property (acc && paddr <= `PIDACC_OFF_IRQ_MASK
		&& paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access refused");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_cfg_gap_zero: assert property (rd_cfg |-> prdata[5:3] == 3'h0)
		else $error("config gap bits set");
	a_enable_readback: assert property (rd_cfg |-> prdata[7] == en_seen)
		else $error("enable bit differs");
	a_busy_window: assert property (rd_cfg |-> prdata[6] == ($past(busy_cnt) != 3'h0))
		else $error("busy flag outside calculation window");
	cover property (rd_cfg && prdata[6]);
	cover property (acc && pslverr);
	cover property ($rose(irq));
endmodule
bind pidacc_top pidacc_sva u_sva (.core_clk(core_clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// File: pidacc_top.v
// pid math accelerator with apb register slave
`include "pidacc_defines.vh"
`default_nettype none
// Overview of operation
// - config bit 7 enables the accelerator; resets to zero.
// - config bit 6 reads one exactly while a calculation runs.
// - config bits 5 to 3 read zero and ignore writes.
// - mode 101 runs the pid step with accumulation, two's complement.
// - mode 000 unsigned (sample+target)*gain_now replaces the result.
// - mode 001 unsigned (sample+target)*gain_now accumulates into the result.
// - mode 010 signed (sample+target)*gain_now replaces the result.
// - mode 011 signed (sample+target)*gain_now accumulates into the result.
// - sample word in high and low bytes, kept over reset.
// - target word in high and low bytes, cleared on reset.
// - gain_now in high and low bytes, cleared on reset.
// - gain_prior in high and low bytes, cleared on reset.
// - writing the sample low byte starts the calculation and sets busy.
// - overflow wraps and sets the error flag; success sets done.
// - pid error is target minus sample, three weighted errors summed.
module pidacc_top (
	input wire core_clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq
);
	localparam ST_IDLE = 2'h0;
	localparam ST_CALC = 2'h1;
	localparam ST_DONE = 2'h2;

	// sequencer timing, counted from edge e that takes the sample low write:
	// - edge e: the state moves to calc, busy rises and the counter loads
	// - edges e+1 to e+3: the counter runs down while the operands stand still
	// - edge e+4: the counter reads one, the sum and the wrap flag are latched
	// - edge e+5: the result lands, busy falls and the status flag is set
	// - edge e+6: the interrupt line follows the status, one cycle late
	// a start is only taken in idle, so a second sample low write while busy
	// neither restarts nor stretches the running calculation
	// writes to the operand registers while busy are not blocked here; they
	// change the live operands and so corrupt the answer, which is why
	// software must wait for busy to fall before touching anything
	// writes to the result bytes while busy are dropped, so a late write
	// cannot tear the value that the sequencer is about to store
	// a sample low write with the enable bit clear stores the byte only

	reg [7:0] config_reg;
	reg busy_reg;
	reg [15:0] sample_reg;
	reg [15:0] target_reg;
	reg [15:0] gain_now_reg;
	reg [15:0] gain_prior_reg;
	reg [15:0] gain_older_reg;
	reg [35:0] result_reg;
	reg [16:0] err_prev_reg;
	reg [16:0] err_older_reg;
	reg [1:0] irq_stat_reg;
	reg [1:0] irq_mask_reg;
	reg [1:0] state_reg;
	reg [3:0] cnt_reg;
	reg [35:0] sum_reg;
	reg ovf_reg;

	// -----------------------------------------------------------------
	// bus decode
	// -----------------------------------------------------------------
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite;
	wire [7:0] wb = pwdata[7:0];
	wire [2:0] mode = config_reg[2:0];
	wire start = wr & (paddr == `PIDACC_OFF_SAMPLE_L) & config_reg[`PIDACC_BIT_EN];
	wire mapped = (paddr[1:0] == 2'h0) & (paddr <= `PIDACC_OFF_IRQ_MASK);

	// -----------------------------------------------------------------
	// arithmetic
	// -----------------------------------------------------------------
	// width notes for the datapath:
	// - the 16-bit operands sum into 17 bits, so no carry of the add is lost
	// - a 17-bit sum times a 16-bit gain needs 33 bits; 34 are kept so the
	//   signed and unsigned products share one width
	// - the pid error is 17 bits signed, so target minus sample never wraps
	// - three 34-bit products sum into 36 bits, the width of the result
	// - the accumulate adder is 37 bits wide; its top bit is the carry out
	//   for unsigned modes and the sign guard for signed modes
	// - non-accumulating modes replace the result and can never wrap
	// - reserved mode codes select a zero term and leave the result at zero
	// the history registers hold raw 17-bit errors; they only move in pid
	// mode, so an arithmetic step between two pid steps keeps the history
	// the multipliers are plain combinational; the four calc cycles give
	// them time to settle before the sum is latched
	// operand sums and products, one signed and one unsigned path
	wire [16:0] usum = {1'b0, sample_reg} + {1'b0, target_reg};
	wire signed [16:0] ssum = $signed({sample_reg[15], sample_reg}) +
		$signed({target_reg[15], target_reg});
	wire [33:0] uprod = {1'b0, usum} * {18'h00000, gain_now_reg};
	wire signed [33:0] sprod = ssum * $signed(gain_now_reg);
	// error now is target minus sample
	wire signed [16:0] err_now = $signed({target_reg[15], target_reg}) -
		$signed({sample_reg[15], sample_reg});
	wire signed [33:0] p0 = err_now * $signed(gain_now_reg);
	wire signed [33:0] p1 = $signed(err_prev_reg) * $signed(gain_prior_reg);
	wire signed [33:0] p2 = $signed(err_older_reg) * $signed(gain_older_reg);
	wire signed [35:0] pid_sum = {{2{p0[33]}}, p0} + {{2{p1[33]}}, p1} +
		{{2{p2[33]}}, p2};

	reg [35:0] term;
	reg [36:0] total;
	reg acc_mode;
	reg signed_mode;
	reg ovf_next;
	// select the term and whether to accumulate
	always @* begin
		term = 36'h000000000;
		acc_mode = 1'b0;
		signed_mode = 1'b1;
		case (mode)
			`PIDACC_MODE_UADD: begin
				term = {2'h0, uprod};
				signed_mode = 1'b0;
			end
			`PIDACC_MODE_UACC: begin
				term = {2'h0, uprod};
				acc_mode = 1'b1;
				signed_mode = 1'b0;
			end
			`PIDACC_MODE_SADD: begin
				term = {{2{sprod[33]}}, sprod};
			end
			`PIDACC_MODE_SACC: begin
				term = {{2{sprod[33]}}, sprod};
				acc_mode = 1'b1;
			end
			`PIDACC_MODE_PID: begin
				term = pid_sum;
				acc_mode = 1'b1;
			end
			default: begin
				term = 36'h000000000;
			end
		endcase
		if (acc_mode) begin
			if (signed_mode) begin
				total = {result_reg[35], result_reg} + {term[35], term};
			end else begin
				total = {1'b0, result_reg} + {1'b0, term};
			end
		end else begin
			total = {term[35], term};
		end
		// wrap detect: carry out unsigned, sign mismatch signed
		if (!acc_mode) begin
			ovf_next = 1'b0;
		end else if (signed_mode) begin
			ovf_next = (total[36] != total[35]);
		end else begin
			ovf_next = total[36];
		end
	end

	// -----------------------------------------------------------------
	// calculation sequencer
	// -----------------------------------------------------------------
	// busy spans from start to completion, the result lands at the end
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			sum_reg <= 36'h000000000;
			ovf_reg <= 1'b0;
			result_reg <= 36'h000000000;
			err_prev_reg <= 17'h00000;
			err_older_reg <= 17'h00000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_CALC;
						busy_reg <= 1'b1;
						cnt_reg <= `PIDACC_CALC_CYCLES;
					end else if (wr) begin
						if (paddr == `PIDACC_OFF_RES_U) result_reg[35:32] <= wb[3:0];
						if (paddr == `PIDACC_OFF_RES_HH) result_reg[31:24] <= wb;
						if (paddr == `PIDACC_OFF_RES_HL) result_reg[23:16] <= wb;
						if (paddr == `PIDACC_OFF_RES_LH) result_reg[15:8] <= wb;
						if (paddr == `PIDACC_OFF_RES_LL) result_reg[7:0] <= wb;
					end
				end
				ST_CALC: begin
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1) begin
						sum_reg <= total[35:0];
						ovf_reg <= ovf_next;
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					result_reg <= sum_reg;
					busy_reg <= 1'b0;
					state_reg <= ST_IDLE;
					if (mode == `PIDACC_MODE_PID) begin
						err_older_reg <= err_prev_reg;
						err_prev_reg <= err_now;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	wire done_evt = (state_reg == ST_DONE);

	// -----------------------------------------------------------------
	// software registers
	// -----------------------------------------------------------------
	// config and coefficients, cleared on reset
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			config_reg <= `PIDACC_CONFIG_RST;
			target_reg <= 16'h0000;
			gain_now_reg <= 16'h0000;
			gain_prior_reg <= 16'h0000;
			gain_older_reg <= 16'h0000;
			irq_mask_reg <= 2'h0;
		end else if (wr) begin
			case (paddr)
				`PIDACC_OFF_CONFIG: config_reg <= {wb[7], 4'h0, wb[2:0]};
				`PIDACC_OFF_TARGET_H: target_reg[15:8] <= wb;
				`PIDACC_OFF_TARGET_L: target_reg[7:0] <= wb;
				`PIDACC_OFF_GNOW_H: gain_now_reg[15:8] <= wb;
				`PIDACC_OFF_GNOW_L: gain_now_reg[7:0] <= wb;
				`PIDACC_OFF_GPRI_H: gain_prior_reg[15:8] <= wb;
				`PIDACC_OFF_GPRI_L: gain_prior_reg[7:0] <= wb;
				`PIDACC_OFF_GOLD_H: gain_older_reg[15:8] <= wb;
				`PIDACC_OFF_GOLD_L: gain_older_reg[7:0] <= wb;
				`PIDACC_OFF_IRQ_MASK: irq_mask_reg <= wb[1:0];
				default: config_reg <= config_reg;
			endcase
		end
	end

	// sample word holds no reset so it survives warm resets
	always @(posedge core_clk) begin
		if (wr && paddr == `PIDACC_OFF_SAMPLE_H) sample_reg[15:8] <= wb;
		if (wr && paddr == `PIDACC_OFF_SAMPLE_L) sample_reg[7:0] <= wb;
	end

	// status bit 0 marks a clean completion, bit 1 a wrapped result
	// a wrapped result sets only the error bit, never the done bit
	// the mask has the same layout; irq is high while a masked-in bit is set
	// the irq flop adds one cycle of lag behind the status bits
	// sticky status, set wins over write-one-to-clear
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_reg <= 2'h0;
			irq <= 1'b0;
		end else begin
			irq_stat_reg[`PIDACC_IRQ_DONE] <= (done_evt & ~ovf_reg) |
				(irq_stat_reg[`PIDACC_IRQ_DONE] &
				~(wr & paddr == `PIDACC_OFF_IRQ_STAT & wb[0]));
			irq_stat_reg[`PIDACC_IRQ_OVF] <= (done_evt & ovf_reg) |
				(irq_stat_reg[`PIDACC_IRQ_OVF] &
				~(wr & paddr == `PIDACC_OFF_IRQ_STAT & wb[1]));
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// -----------------------------------------------------------------
	// apb answer
	// -----------------------------------------------------------------
	reg [7:0] rd;
	// read mux
	always @* begin
		case (paddr)
			`PIDACC_OFF_CONFIG: rd = {config_reg[7], busy_reg, 3'h0, config_reg[2:0]};
			`PIDACC_OFF_SAMPLE_H: rd = sample_reg[15:8];
			`PIDACC_OFF_SAMPLE_L: rd = sample_reg[7:0];
			`PIDACC_OFF_TARGET_H: rd = target_reg[15:8];
			`PIDACC_OFF_TARGET_L: rd = target_reg[7:0];
			`PIDACC_OFF_GNOW_H: rd = gain_now_reg[15:8];
			`PIDACC_OFF_GNOW_L: rd = gain_now_reg[7:0];
			`PIDACC_OFF_GPRI_H: rd = gain_prior_reg[15:8];
			`PIDACC_OFF_GPRI_L: rd = gain_prior_reg[7:0];
			`PIDACC_OFF_GOLD_H: rd = gain_older_reg[15:8];
			`PIDACC_OFF_GOLD_L: rd = gain_older_reg[7:0];
			`PIDACC_OFF_RES_U: rd = {4'h0, result_reg[35:32]};
			`PIDACC_OFF_RES_HH: rd = result_reg[31:24];
			`PIDACC_OFF_RES_HL: rd = result_reg[23:16];
			`PIDACC_OFF_RES_LH: rd = result_reg[15:8];
			`PIDACC_OFF_RES_LL: rd = result_reg[7:0];
			`PIDACC_OFF_IRQ_STAT: rd = {6'h00, irq_stat_reg};
			`PIDACC_OFF_IRQ_MASK: rd = {6'h00, irq_mask_reg};
			default: rd = 8'h00;
		endcase
	end

	// apb answer timing:
	// - setup cycle: psel high, penable low, nothing happens here
	// - first access cycle: pready is still low, the read mux is captured
	// - second access cycle: pready, prdata and pslverr stand for one cycle
	// - the write takes effect at the edge that samples pready high
	// unmapped or misaligned addresses answer with pslverr and read zero;
	// their writes fall through every decode and change nothing
	// read data carries the register in the low byte, upper bits zero
	// write answers return zero read data
	// pslverr is only ever high together with pready
	// one wait state: pready rises in the second access cycle
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata <= pwrite ? 32'h00000000 : {24'h000000, rd};
				pslverr <= ~mapped;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: pidacc_top_tb.sv
// self-checking bench for the pid accelerator
`include "pidacc_defines.vh"
`default_nettype none
`define CHK(nm, exp, got) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("wrong value %s expected %h seen %h", nm, exp, got); \
	end \
end
module pidacc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// stimulus, scenarios and verdict
	// ------------------------------------------------------------
	logic core_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, re;
	logic [7:0] rq;
	logic [15:0] gn, gp, go;
	logic signed [35:0] z1 = 36'h0, z2 = 36'h0;
	logic [35:0] model = 36'h0;
	int checked = 0, fail_count = 0;
	always #10 core_clk = ~core_clk;
	pidacc_top dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50)
			fail_count++;
		rq = prdata[7:0];
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// load the three coefficients, high byte first
	task automatic setg(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		logic [47:0] v;
		v = {a, b, c};
		{gn, gp, go} = v;
		for (int k = 0; k < 6; k++)
			apb(1'h1, 12'(`PIDACC_OFF_GNOW_H + 4 * k), v[47 - 8 * k -: 8]);
	endtask
	// start one calculation, wait for it, compare result and status
	task automatic run(input logic [2:0] m, input logic [15:0] s, input logic [15:0] t);
		logic signed [35:0] a, p, e;
		logic [36:0] sum;
		logic [39:0] r;
		int n;
		n = 0;
		a = m[1] ? 36'($signed(s)) + 36'($signed(t)) : 36'(s) + 36'(t);
		p = a * (m[1] ? 36'($signed(gn)) : 36'(gn));
		if (m == `PIDACC_MODE_PID) begin
			e = 36'($signed(t)) - 36'($signed(s));
			p = e * 36'($signed(gn)) + z1 * 36'($signed(gp)) + z2 * 36'($signed(go));
			z2 = z1;
			z1 = e;
		end
		sum = (m[0] ? {1'h0, model} : 37'h0) + {1'h0, p};
		model = sum[35:0];
		apb(1'h1, `PIDACC_OFF_IRQ_STAT, 8'h03);
		apb(1'h1, `PIDACC_OFF_CONFIG, {5'h10, m});
		apb(1'h1, `PIDACC_OFF_TARGET_H, t[15:8]);
		apb(1'h1, `PIDACC_OFF_TARGET_L, t[7:0]);
		apb(1'h1, `PIDACC_OFF_SAMPLE_H, s[15:8]);
		apb(1'h1, `PIDACC_OFF_SAMPLE_L, s[7:0]);
		apb(1'h0, `PIDACC_OFF_CONFIG, 8'h0);
		`CHK("busy after start", {5'h18, m}, rq)
		do apb(1'h0, `PIDACC_OFF_CONFIG, 8'h0); while (rq[6] === 1'h1 && ++n < 20);
		`CHK("busy cleared", 1'h0, rq[6])
		r = 40'h0;
		for (int k = 0; k < 5; k++) begin
			apb(1'h0, 12'(`PIDACC_OFF_RES_U + 4 * k), 8'h0);
			r = {r[31:0], rq};
		end
		`CHK("result", {4'h0, model}, r)
		apb(1'h0, `PIDACC_OFF_IRQ_STAT, 8'h0);
		`CHK("status", (m == 3'h1 && sum[36]) ? 8'h02 : 8'h01, rq)
		`CHK("irq while masked", 1'h0, irq)
		$display("calculation in mode %h done", m);
	endtask
	// reset values, read/write access, unused config bits, unmapped address
	task automatic t_regs;
		apb(1'h0, `PIDACC_OFF_CONFIG, 8'h0);
		`CHK("config reset", `PIDACC_CONFIG_RST, rq)
		for (int k = 1; k < 9; k++) begin
			apb(1'h0, 12'(4 * k), 8'h0);
			if (k > 2)
				`CHK("coefficient reset", 8'h00, rq)
			apb(1'h1, 12'(4 * k), 8'(8'h5a + k));
			apb(1'h0, 12'(4 * k), 8'h0);
			`CHK("readback", 8'(8'h5a + k), rq)
		end
		apb(1'h1, `PIDACC_OFF_CONFIG, 8'hfd);
		apb(1'h0, `PIDACC_OFF_CONFIG, 8'h0);
		`CHK("config write", 8'h85, rq)
		apb(1'h1, 12'h048, 8'hff);
		`CHK("unmapped write error", 1'h1, re)
		apb(1'h0, 12'h048, 8'h0);
		`CHK("unmapped read", 9'h100, {re, rq})
		$display("register test done");
	endtask
	// saturate the result by software, then an accumulation wraps it
	task automatic t_ovf;
		for (int k = 0; k < 5; k++)
			apb(1'h1, 12'(`PIDACC_OFF_RES_U + 4 * k), 8'hff);
		model = 36'hfffffffff;
		setg(16'h0001, 16'h0000, 16'h0000);
		run(`PIDACC_MODE_UACC, 16'h0001, 16'h0000);
		$display("overflow test done");
	endtask
	// unmask the pending overflow flag, then clear it by writing one
	task automatic t_irq;
		apb(1'h1, `PIDACC_OFF_IRQ_MASK, 8'h02);
		repeat (2) @(posedge core_clk);
		`CHK("irq raised", 1'h1, irq)
		apb(1'h1, `PIDACC_OFF_IRQ_STAT, 8'h02);
		repeat (2) @(posedge core_clk);
		`CHK("irq cleared", 1'h0, irq)
		$display("interrupt test done");
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence: all five defined modes, three pid steps for the error history
	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'h1;
		t_regs;
		setg(16'h0003, 16'h0000, 16'h0000);
		run(`PIDACC_MODE_UADD, 16'hff00, 16'h0200);
		run(`PIDACC_MODE_UACC, 16'hff00, 16'h0200);
		setg(16'h0005, 16'h0000, 16'h0000);
		run(`PIDACC_MODE_SADD, 16'hfff0, 16'h0004);
		run(`PIDACC_MODE_SACC, 16'hfff0, 16'h0004);
		setg(16'h0002, 16'h0003, 16'h0005);
		run(`PIDACC_MODE_PID, 16'h000a, 16'h001e);
		run(`PIDACC_MODE_PID, 16'h0019, 16'h001e);
		run(`PIDACC_MODE_PID, 16'h001e, 16'h001e);
		t_ovf;
		t_irq;
		conclude;
	end
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		conclude;
	end
endmodule
`default_nettype wire
